// File: vme_slot_window_decoder_bench.sv
`timescale 1ns/1ps
module vme_slot_window_decoder_bench
  import vsw_pkg::*;
;
  logic        clk_in, rstn_in, req_in, wr_in, byte_in, usr_we_in;
  logic        busy_out, done_out, err_out, pos_bad_out;
  logic        acc_pulse_out, acc_wr_out;
  logic [2:0]  rack_in;
  logic [3:0]  slot_in;
  logic [1:0]  usr_be_in;
  logic [13:0] usr_addr_in, acc_addr_out;
  logic [23:0] addr_in, win_base_out;
  logic [15:0] wdata_in, rdata_out, usr_wdata_in, usr_rdata_out;
  logic [31:0] seed;
  int          err_count, total_checks, cyc, acc_cnt;

  vsw_bus_if bus();
  vsw_master_end #(.TMO_CYC_P(8)) vsw_master_end_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .req_in(req_in), .wr_in(wr_in),
    .byte_in(byte_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .busy_out(busy_out), .done_out(done_out), .err_out(err_out),
    .rdata_out(rdata_out), .bus(bus));
  vsw_slave_end vsw_slave_end_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .rack_in(rack_in),
    .slot_in(slot_in), .usr_addr_in(usr_addr_in), .usr_we_in(usr_we_in),
    .usr_be_in(usr_be_in), .usr_wdata_in(usr_wdata_in),
    .usr_rdata_out(usr_rdata_out), .acc_pulse_out(acc_pulse_out),
    .acc_wr_out(acc_wr_out), .acc_addr_out(acc_addr_out),
    .win_base_out(win_base_out), .pos_bad_out(pos_bad_out), .bus(bus));
  vsw_chk vsw_chk_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .am(bus.am), .addr(bus.addr),
    .as_n(bus.as_n), .ds_n(bus.ds_n), .write_n(bus.write_n),
    .m_data_oe(bus.m_data_oe), .s_data_oe(bus.s_data_oe),
    .s_dtack_oe(bus.s_dtack_oe));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cyc++;
    if (acc_pulse_out === 1'b1)
      acc_cnt++;
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Window base from rack and slot
  function automatic logic [23:0] base(input logic [2:0] r,
                                       input logic [3:0] s);
    logic [3:0] nb;
    logic [3:0] so;
    nb = (r == 3'h0) ? 4'h0 : 4'hF - {1'h0, r};
    so = s - 4'h2;
    return {nb, so[2:0], 17'h0};
  endfunction : base

  task chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task xfer(input logic w, input logic b, input logic [23:0] a,
            input logic [15:0] d);
    @(posedge clk_in);
    #1;
    req_in = 1'b1;
    wr_in = w;
    byte_in = b;
    addr_in = a;
    wdata_in = d;
    @(posedge clk_in);
    #1;
    req_in = 1'b0;
    chk(24'(busy_out), 24'h1);
    repeat (40)
    begin
      @(posedge clk_in);
      #1;
      if (done_out === 1'b1)
        break;
    end
    chk(24'({busy_out, done_out}), 24'h1);
  endtask : xfer

  task pos(input logic [2:0] r, input logic [3:0] s);
    logic [23:0] b;
    logic [23:0] a;
    logic [31:0] x;
    logic [15:0] w;
    logic [15:0] d;
    logic        bad;
    int          n;
    @(posedge clk_in);
    #1;
    rstn_in = 1'b0;
    rack_in = r;
    slot_in = s;
    repeat (3) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    n = acc_cnt;
    b = base(r, s);
    bad = (s < 4'h2) || (s > 4'h9);
    chk(24'(pos_bad_out), 24'(bad));
    if (!bad)
    begin
      chk(win_base_out, b);
      x = rnd();
      w = x[31:16];
      d = x[15:0];
      a = b | {9'h0, x[14:1], 1'h0};
      xfer(1'b1, 1'b0, a, w);
      chk(24'(err_out), 24'h0);
      chk(24'({acc_wr_out, acc_addr_out}), 24'({1'b1, a[14:1]}));
      xfer(1'b0, 1'b0, a, 16'h0);
      chk(24'(rdata_out), 24'(w));
      xfer(1'b1, 1'b1, a, {8'h00, d[7:0]});
      xfer(1'b0, 1'b1, a | 24'h1, 16'h0);
      chk(24'(rdata_out), 24'({8'h00, w[7:0]}));
      @(posedge clk_in);
      #1;
      usr_addr_in = a[14:1];
      @(posedge clk_in);
      #1;
      chk(24'(usr_rdata_out), 24'({d[7:0], w[7:0]}));
      usr_addr_in = 14'h3FFF;
      usr_wdata_in = d;
      usr_we_in = 1'b1;
      @(posedge clk_in);
      #1;
      usr_we_in = 1'b0;
      xfer(1'b0, 1'b0, b | 24'h7FFE, 16'h0);
      chk(24'(rdata_out), 24'(d));
    end
    foreach (x[i])
      if (i < 4)
      begin
        a = (i == 0) ? b + 24'h8000 : (i == 1) ? b ^ 24'h20000 :
            (i == 2) ? b ^ 24'h100000 : 24'h7FFFFE;
        xfer(1'b0, 1'b0, a, 16'h0);
        chk(24'(err_out), 24'h1);
      end
    // Taken accesses: five hits in a good slot, none on misses
    chk(24'(acc_cnt - n), bad ? 24'h0 : 24'h5);
  endtask : pos

  task give_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    logic [31:0] sd;
    seed = 32'h9F3DF451;
    rstn_in = 1'b0;
    {req_in, wr_in, byte_in, usr_we_in} = 4'h0;
    rack_in = 3'h0;
    slot_in = 4'h2;
    usr_be_in = 2'h3;
    usr_addr_in = 14'h0;
    addr_in = 24'h0;
    wdata_in = 16'h0;
    usr_wdata_in = 16'h0;
    for (int i = 0; i < 12; i++)
    begin
      sd = rnd();
      if (i < 8)
        pos(3'(i), 4'h2 + {1'h0, sd[2:0]});
      else
        pos(sd[6:4], (i == 8) ? 4'h9 : (i == 9) ? 4'h2 :
            (i == 10) ? 4'h1 : 4'hA);
    end
    give_verdict();
  end
endmodule : vme_slot_window_decoder_bench

// File: vsw_bus_if.sv
`timescale 1ns/1ps
interface vsw_bus_if;
  import vsw_pkg::*;

  // Master driven
  logic [AM_W-1:0]   am;
  logic [ADDR_W-1:1] addr;
  logic              as_n;
  logic [LANES-1:0]  ds_n;
  logic              write_n;
  logic [DATA_W-1:0] m_data;
  logic              m_data_oe;

  // Slave driven
  logic [DATA_W-1:0] s_data;
  logic              s_data_oe;
  logic              s_dtack_oe;

  // Resolved wires
  logic [DATA_W-1:0] data;
  logic              dtack_n;

  assign data    = s_data_oe ? s_data : (m_data_oe ? m_data : BUS_IDLE);
  assign dtack_n = ~s_dtack_oe;

  modport master (
    output am,
    output addr,
    output as_n,
    output ds_n,
    output write_n,
    output m_data,
    output m_data_oe,
    input  data,
    input  dtack_n
  );

  modport slave (
    input  am,
    input  addr,
    input  as_n,
    input  ds_n,
    input  write_n,
    input  data,
    output s_data,
    output s_data_oe,
    output s_dtack_oe
  );

endinterface : vsw_bus_if

// File: vsw_chk_sva.sv
`timescale 1ns/1ps
module vsw_chk
  import vsw_pkg::*;
(
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              rstn_in,
  // Backplane
  input wire logic [AM_W-1:0]   am,
  input wire logic [ADDR_W-1:1] addr,
  input wire logic              as_n,
  input wire logic [LANES-1:0]  ds_n,
  input wire logic              write_n,
  input wire logic              m_data_oe,
  input wire logic              s_data_oe,
  input wire logic              s_dtack_oe
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // Bits between window and slot step
  wire logic [1:0] gap = addr[16:15];
  wire logic       usr = ({addr, 1'b0} >= USR_LO) && ({addr, 1'b0} <= USR_HI);

  property p_am;
    !as_n |-> am == AM_STD_NP;
  endproperty
  a_am: assert property (p_am)
    else $error("bad access type");
  property p_hit;
    $rose(s_dtack_oe) |-> $past(am) == AM_STD_NP && !$past(as_n);
  endproperty
  a_hit: assert property (p_hit)
    else $error("ack without valid request");
  property p_lane;
    $rose(s_dtack_oe) |-> $past(ds_n) != DS_IDLE;
  endproperty
  a_lane: assert property (p_lane)
    else $error("ack without lane strobe");
  property p_win;
    $rose(s_dtack_oe) |-> $past(gap) == 2'h0;
  endproperty
  a_win: assert property (p_win)
    else $error("ack outside 32K window");
  property p_usr;
    $rose(s_dtack_oe) |-> !$past(usr);
  endproperty
  a_usr: assert property (p_usr)
    else $error("ack in user region");
  property p_rd;
    s_data_oe |-> s_dtack_oe && write_n;
  endproperty
  a_rd: assert property (p_rd)
    else $error("slave drives data off a read");
  property p_rel;
    $rose(as_n) |-> ##[1:2] !s_dtack_oe;
  endproperty
  a_rel: assert property (p_rel)
    else $error("ack held after release");
  property p_idle;
    as_n [*3] |-> !s_dtack_oe && !s_data_oe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("slave drives idle bus");
  property p_single;
    $fell(s_dtack_oe) |-> as_n;
  endproperty
  a_single: assert property (p_single)
    else $error("strobe kept across transfers");
  property p_wdat;
    !as_n && !write_n |-> m_data_oe;
  endproperty
  a_wdat: assert property (p_wdat)
    else $error("write without data");
endmodule : vsw_chk

// File: vsw_master_end.sv
`timescale 1ns/1ps
module vsw_master_end
  import vsw_pkg::*;
#(
  parameter int TMO_CYC_P = TMO_CYC
)
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // Transfer request
  input  wire logic              req_in,
  input  wire logic              wr_in,
  input  wire logic              byte_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  // Transfer answer
  output logic                   busy_out,
  output logic                   done_out,
  output logic                   err_out,
  output logic      [DATA_W-1:0] rdata_out,
  // Backplane
  vsw_bus_if.master              bus
);

  if (TMO_CYC_P < 1 || TMO_CYC_P > 65535)
  begin : g_chk
    $error("timeout count out of range");
  end

  typedef enum logic [1:0] {
    M_IDLE,
    M_ADDR,
    M_WAIT,
    M_REL
  } vsw_mst_t;

  vsw_mst_t            state_r;
  logic [ADDR_W-1:1]   addr_r;
  logic                as_n_r;
  logic [LANES-1:0]    ds_n_r;
  logic [LANES-1:0]    lanes_r;
  logic                write_n_r;
  logic [DATA_W-1:0]   wdata_r;
  logic                oe_r;
  logic                byte_r;
  logic                odd_r;
  logic [15:0]         cnt_r;
  logic                busy_r;
  logic                done_r;
  logic                err_r;
  logic [DATA_W-1:0]   rdata_r;

  wire logic [LANES-1:0]  lanes;
  wire logic [DATA_W-1:0] wplace;
  wire logic [DATA_W-1:0] rpick;
  wire logic              tmo;

  assign lanes  = !byte_in ? 2'h0 : (addr_in[0] ? 2'h2 : 2'h1);
  assign wplace = !byte_in ? wdata_in :
                  (addr_in[0] ? {8'hFF, wdata_in[7:0]} :
                                {wdata_in[7:0], 8'hFF});
  assign rpick  = !byte_r ? bus.data :
                  (odd_r ? {8'h00, bus.data[7:0]} :
                           {8'h00, bus.data[15:8]});
  assign tmo    = (cnt_r == 16'(TMO_CYC_P - 1));

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r   <= M_IDLE;
      addr_r    <= '0;
      as_n_r    <= 1'b1;
      ds_n_r    <= DS_IDLE;
      lanes_r   <= DS_IDLE;
      write_n_r <= 1'b1;
      wdata_r   <= BUS_IDLE;
      oe_r      <= 1'b0;
      byte_r    <= 1'b0;
      odd_r     <= 1'b0;
      cnt_r     <= 16'h0000;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      err_r     <= 1'b0;
      rdata_r   <= DATA_RST;
    end
    else
    begin
      done_r <= 1'b0;
      case (state_r)
        M_IDLE:
        begin
          err_r <= 1'b0;
          if (req_in)
          begin
            addr_r    <= addr_in[ADDR_W-1:1];
            as_n_r    <= 1'b0;
            lanes_r   <= lanes;
            write_n_r <= !wr_in;
            wdata_r   <= wplace;
            oe_r      <= wr_in;
            byte_r    <= byte_in;
            odd_r     <= addr_in[0];
            busy_r    <= 1'b1;
            cnt_r     <= 16'h0000;
            state_r   <= M_ADDR;
          end
        end
        M_ADDR:
        begin
          ds_n_r  <= lanes_r;
          state_r <= M_WAIT;
        end
        M_WAIT:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (!bus.dtack_n || tmo)
          begin
            rdata_r <= rpick;
            err_r   <= bus.dtack_n;
            as_n_r  <= 1'b1;
            ds_n_r  <= DS_IDLE;
            oe_r    <= 1'b0;
            state_r <= M_REL;
          end
        end
        M_REL:
        begin
          if (bus.dtack_n)
          begin
            busy_r  <= 1'b0;
            done_r  <= 1'b1;
            state_r <= M_IDLE;
          end
        end
        default:
          state_r <= M_IDLE;
      endcase
    end
  end

  assign bus.am        = AM_STD_NP;
  assign bus.addr      = addr_r;
  assign bus.as_n      = as_n_r;
  assign bus.ds_n      = ds_n_r;
  assign bus.write_n   = write_n_r;
  assign bus.m_data    = wdata_r;
  assign bus.m_data_oe = oe_r;
  assign busy_out      = busy_r;
  assign done_out      = done_r;
  assign err_out       = err_r;
  assign rdata_out     = rdata_r;

endmodule : vsw_master_end

// File: vsw_pkg.sv
package vsw_pkg;

  // Bus shape
  localparam int          ADDR_W     = 24;
  localparam int          DATA_W     = 16;
  localparam int          AM_W       = 6;
  localparam int          LANES      = 2;
  localparam int          WIN_AW_DEF = 15;

  // Access type and decode
  localparam logic [5:0]  AM_STD_NP  = 6'h39;
  localparam logic [3:0]  SLOT_MIN   = 4'h2;
  localparam logic [3:0]  SLOT_MAX   = 4'h9;
  localparam logic [3:0]  NIB_TOP    = 4'hF;
  localparam logic [23:0] USR_LO     = 24'h100000;
  localparam logic [23:0] USR_HI     = 24'h7FFFFF;

  // Idle and reset values
  localparam logic [15:0] BUS_IDLE   = 16'hFFFF;
  localparam logic [15:0] DATA_RST   = 16'h0000;
  localparam logic [1:0]  DS_IDLE    = 2'h3;

  // Timing
  localparam int          CLK_NS     = 10;
  localparam int          TMO_NS     = 1000;
  localparam int          TMO_CYC    = (TMO_NS + CLK_NS - 1) / CLK_NS;

endpackage : vsw_pkg

// File: vsw_slave_end.sv
`timescale 1ns/1ps
module vsw_slave_end
  import vsw_pkg::*;
#(
  parameter int WIN_AW = WIN_AW_DEF
)
(
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                rstn_in,
  // Position straps
  input  wire logic [2:0]          rack_in,
  input  wire logic [3:0]          slot_in,
  // Local port of the dual-port RAM
  input  wire logic [WIN_AW-2:0]   usr_addr_in,
  input  wire logic                usr_we_in,
  input  wire logic [LANES-1:0]    usr_be_in,
  input  wire logic [DATA_W-1:0]   usr_wdata_in,
  output logic      [DATA_W-1:0]   usr_rdata_out,
  // Access reporting and position status
  output logic                     acc_pulse_out,
  output logic                     acc_wr_out,
  output logic      [WIN_AW-2:0]   acc_addr_out,
  output logic      [ADDR_W-1:0]   win_base_out,
  output logic                     pos_bad_out,
  // Backplane
  vsw_bus_if.slave                 bus
);

  localparam int WDEPTH = 2 ** (WIN_AW - 1);

  if (WIN_AW != WIN_AW_DEF)
  begin : g_chk
    $error("window must be 32K bytes");
  end

  typedef enum logic [0:0] {
    S_IDLE,
    S_ACK
  } vsw_sst_t;

  vsw_sst_t            state_r;
  vsw_sst_t            state_nxt;
  logic                strap_ld_r;
  logic [2:0]          rack_r;
  logic [3:0]          slot_r;
  logic [DATA_W-1:0]   s_data_r;
  logic                s_data_oe_r;
  logic                dtack_oe_r;
  logic                acc_pulse_r;
  logic                acc_wr_r;
  logic [WIN_AW-2:0]   acc_addr_r;
  logic [ADDR_W-1:0]   base_r;
  logic                pos_bad_r;

  // Window base from position
  wire logic [3:0]        nib;
  wire logic [3:0]        slot_ofs;
  wire logic [2:0]        slot_code;
  wire logic [ADDR_W-1:0] base;
  wire logic              slot_ok;
  wire logic [ADDR_W-1:0] full_addr;
  wire logic              am_ok;
  wire logic              win_match;
  wire logic              usr_rgn;
  wire logic              strobe;
  wire logic              hit;
  wire logic              released;
  wire logic              take;
  wire logic              bus_wr;
  wire logic [WIN_AW-2:0] widx;
  wire logic [DATA_W-1:0] bus_rd_word;

  assign nib       = (rack_r == 3'h0) ? 4'h0 : NIB_TOP - {1'b0, rack_r};
  assign slot_ofs  = slot_r - SLOT_MIN;
  assign slot_code = slot_ofs[2:0];
  assign base      = {nib, slot_code, 17'h00000};
  assign slot_ok   = (slot_r >= SLOT_MIN) && (slot_r <= SLOT_MAX);
  assign full_addr = {bus.addr, 1'b0};
  assign am_ok     = (bus.am == AM_STD_NP);
  assign win_match = (full_addr[ADDR_W-1:WIN_AW] == base[ADDR_W-1:WIN_AW]);
  assign usr_rgn   = (rack_r == 3'h0) && (full_addr >= USR_LO) &&
                     (full_addr <= USR_HI);
  assign strobe    = !bus.as_n && (bus.ds_n != DS_IDLE);
  assign hit       = strap_ld_r && slot_ok && am_ok && win_match && !usr_rgn;
  assign take      = (state_r == S_IDLE) && strobe && hit;
  assign released  = bus.as_n || (bus.ds_n == DS_IDLE);
  assign bus_wr    = take && !bus.write_n;
  assign widx      = full_addr[WIN_AW-1:1];

  // Position caught once after reset release
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      strap_ld_r <= 1'b0;
      rack_r     <= 3'h0;
      slot_r     <= 4'h0;
    end
    else if (!strap_ld_r)
    begin
      strap_ld_r <= 1'b1;
      rack_r     <= rack_in;
      slot_r     <= slot_in;
    end
  end

  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic [7:0] mem [WDEPTH];
    logic [7:0] urd_r;

    assign bus_rd_word[8*l +: 8] = mem[widx];
    assign usr_rdata_out[8*l +: 8] = urd_r;

    always_ff @(posedge clk_in)
    begin
      if (usr_we_in && usr_be_in[l])
        mem[usr_addr_in] <= usr_wdata_in[8*l +: 8];
      if (bus_wr && !bus.ds_n[l])
        mem[widx] <= bus.data[8*l +: 8];
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        urd_r <= 8'h00;
      else
        urd_r <= mem[usr_addr_in];
    end
  end

  // Acknowledge held until strobes drop
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:
      begin
        if (take)
          state_nxt = S_ACK;
      end
      S_ACK:
      begin
        if (released)
          state_nxt = S_IDLE;
      end
      default:
        state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      state_r <= S_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s_data_r    <= DATA_RST;
      s_data_oe_r <= 1'b0;
      dtack_oe_r  <= 1'b0;
    end
    else if (take)
    begin
      s_data_r    <= bus_rd_word;
      s_data_oe_r <= bus.write_n;
      dtack_oe_r  <= 1'b1;
    end
    else if (state_r == S_ACK && released)
    begin
      s_data_oe_r <= 1'b0;
      dtack_oe_r  <= 1'b0;
    end
  end

  // Access report and position status
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      acc_pulse_r <= 1'b0;
      acc_wr_r    <= 1'b0;
      acc_addr_r  <= '0;
      base_r      <= '0;
      pos_bad_r   <= 1'b0;
    end
    else
    begin
      acc_pulse_r <= take;
      base_r      <= base;
      pos_bad_r   <= strap_ld_r && !slot_ok;
      if (take)
      begin
        acc_wr_r   <= !bus.write_n;
        acc_addr_r <= widx;
      end
    end
  end

  assign bus.s_data     = s_data_r;
  assign bus.s_data_oe  = s_data_oe_r;
  assign bus.s_dtack_oe = dtack_oe_r;
  assign acc_pulse_out  = acc_pulse_r;
  assign acc_wr_out     = acc_wr_r;
  assign acc_addr_out   = acc_addr_r;
  assign win_base_out   = base_r;
  assign pos_bad_out    = pos_bad_r;

endmodule : vsw_slave_end
